// ===== rtl/rtu_core.sv
// return instruction unit: decode, condition test, pc and shadow restore
// Functional notes
// RL1 - conditional return loads pc only if true
// RL2 - pop stack after top copied to pc
// RL3 - false condition: stack kept, next instruction
// RL4 - taken four cycles, not taken two
// RL5 - conditional return never repeats
// RL6 - delayed variants run two following words
// RL7 - delayed conditions latched before delay slots
// RL8 - delayed variants two cycles, not repeatable
// RL9 - delayed return always loads top entry
// RL10 - enabling return pops, clears mask, restores
// RL11 - enabling return four cycles, not repeatable
// RL12 - enabling return may change restored status
// RL13 - conditional returns change no status bits
// RL14 - shadow set holds eleven core registers
// RL15 - mask and external flag never shadowed
// RL16 - eight entry lifo, bottom duplicated on pop
// RL17 - selected conditions combined by logical and
// RL18 - condition fields from low opcode bits
`default_nettype none
module rtu_core
    import rtu_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                instr_valid,
    input  wire logic [15:0]         instr_word,
    input  wire logic                word_wait,
    input  wire logic                repeat_active,
    input  wire logic                push,
    input  wire logic [15:0]         push_data,
    input  wire logic [15:0]         pc_next_seq,
    input  wire logic [31:0]         accum,
    input  wire logic                carry_flag,
    input  wire logic                overflow_flag,
    input  wire logic                test_control_flag,
    input  wire logic                branch_input_pin,
    input  wire rtu_shadow_type      shadow_in,
    input  wire logic                global_irq_mask_in,
    input  wire logic                external_flag_in,
    output logic                     busy,
    output logic                     pc_load,
    output logic [15:0]              pc_value,
    output logic                     flush_fetch,
    output logic                     repeat_cancel,
    output logic                     restore_valid,
    output rtu_shadow_type           restore_out,
    output logic                     global_irq_mask_clr,
    output logic [2:0]               cycles_done,
    output logic [15:0]              stack_top_entry
);
    typedef enum logic [1:0] {RTU_IDLE, RTU_SLOT, RTU_WAIT} rtu_state_type;
    rtu_state_type state_q;
    rtu_kind_type  kind, kind_q;
    logic [1:0]    fetch_q;
    logic [1:0]    slot_q;
    logic [2:0]    cyc_q;
    logic          cond_q;
    logic          cond_now;
    logic          pin_s1_q, pin_s2_q;
    logic          take_now;
    logic [15:0]   ent [RTU_STACK_DEPTH];
    rtu_stack_if   sif ();

    // lifo with pop priority over push
    rtu_stack #(.DEPTH(RTU_STACK_DEPTH)) u_stack (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .push      (push),
        .push_data (push_data),
        .sif       (sif),
        .entries   (ent)
    );
    assign stack_top_entry = sif.top;

    // pin synchroniser
    // both stages reset to the idle high level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= branch_input_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // decode
    always_comb begin
        kind = RTU_K_NONE;
        if (instr_word == RTU_OP_RETURN_DELAYED) begin
            kind = RTU_K_RETURN_DELAYED;
        end else if (instr_word == RTU_OP_RETURN_ENABLE_IRQ) begin
            kind = RTU_K_RETURN_ENABLE_IRQ;
        end else if (instr_word[15:8] == RTU_OP_CRETD_HI) begin
            kind = RTU_K_CRETD;
        end else if (instr_word[15:10] == RTU_OP_CRET) begin
            kind = RTU_K_CRET;
        end
    end

    // condition evaluation
    always_comb begin
        logic [3:0] en;
        logic [3:0] val;
        logic       zero;
        logic       neg;
        en   = instr_word[RTU_CEN_LSB +: 4]; // RL18
        val  = instr_word[RTU_CVAL_LSB +: 4]; // RL18
        zero = (accum == 32'h0000_0000);
        neg  = accum[31];
        cond_now = 1'b1;
        if (en[3] && (zero != val[3])) cond_now = 1'b0; // RL17
        if (en[2] && (neg != val[2])) cond_now = 1'b0; // RL17
        if (en[1] && (carry_flag != val[1])) cond_now = 1'b0; // RL17
        if (en[0] && (overflow_flag != val[0])) cond_now = 1'b0; // RL17
        unique case (instr_word[RTU_TP_LSB +: 2]) // RL18
            RTU_TP_PIN:  if (pin_s2_q) cond_now = 1'b0; // RL17
            RTU_TP_TC:   if (!test_control_flag) cond_now = 1'b0;
            RTU_TP_NTC:  if (test_control_flag) cond_now = 1'b0;
            RTU_TP_NONE: cond_now = cond_now;
        endcase
    end

    assign take_now = instr_valid && state_q == RTU_IDLE && !word_wait;

    // sequencing
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= RTU_IDLE;
            kind_q  <= RTU_K_NONE;
            cond_q  <= 1'b0;
            slot_q  <= 2'h0;
            fetch_q <= 2'h0;
        end else begin
            unique case (state_q)
                RTU_IDLE: if (take_now && kind != RTU_K_NONE) begin
                    kind_q <= kind;
                    cond_q <= (kind == RTU_K_CRET || kind == RTU_K_CRETD)
                              ? cond_now : 1'b1; // RL7
                    if (kind == RTU_K_CRETD || kind == RTU_K_RETURN_DELAYED) begin
                        state_q <= RTU_SLOT; // RL6
                        slot_q  <= RTU_DELAY_WORDS;
                    end else begin
                        state_q <= RTU_WAIT;
                        fetch_q <= (kind == RTU_K_RETURN_ENABLE_IRQ || cond_now)
                                   ? RTU_FETCH_TAKEN : RTU_FETCH_ONE; // RL4
                    end
                end
                RTU_SLOT: if (instr_valid && !word_wait) begin
                    slot_q <= slot_q - 2'h1; // RL6
                    if (slot_q == 2'h1) begin
                        state_q <= RTU_IDLE;
                    end
                end
                RTU_WAIT: if (!word_wait) begin
                    fetch_q <= fetch_q - 2'h1;
                    if (fetch_q == 2'h1) begin
                        state_q <= RTU_IDLE;
                    end
                end
            endcase
        end
    end

    // completion pulse for the non-delayed and delayed returns
    logic finish;
    logic slot_end;
    assign slot_end = state_q == RTU_SLOT && instr_valid && !word_wait
                      && slot_q == 2'h1;
    assign finish = (state_q == RTU_WAIT && !word_wait && fetch_q == 2'h1)
                    || slot_end;
    assign sif.pop = finish && cond_q; // RL2 RL3 RL9

    // registered results, pulses last one cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pc_load             <= 1'b0;
            pc_value            <= RTU_PC_RST;
            flush_fetch         <= 1'b0;
            restore_valid       <= 1'b0;
            restore_out         <= '0;
            global_irq_mask_clr <= 1'b0;
            cycles_done         <= 3'h0;
        end else begin
            pc_load             <= 1'b0;
            flush_fetch         <= 1'b0;
            restore_valid       <= 1'b0;
            global_irq_mask_clr <= 1'b0;
            if (finish) begin
                pc_load  <= 1'b1;
                pc_value <= cond_q ? sif.top : pc_next_seq; // RL1 RL3
                flush_fetch <= cond_q && state_q == RTU_WAIT; // RL4
                if (state_q == RTU_SLOT) begin
                    cycles_done <= RTU_CYC_DELAY; // RL8
                end else begin
                    cycles_done <= cond_q ? RTU_CYC_TAKEN
                                          : RTU_CYC_NOTAKE; // RL4 RL11
                end
                if (kind_q == RTU_K_RETURN_ENABLE_IRQ) begin
                    restore_valid       <= 1'b1; // RL10 RL12 RL13
                    global_irq_mask_clr <= 1'b1; // RL10 RL11
                    restore_out <= shadow_in; // RL14
                    restore_out.status_reg_zero[RTU_ST0_MASK_BIT]
                        <= 1'b0; // RL15
                    restore_out.status_reg_one[RTU_ST1_XF_BIT]
                        <= external_flag_in; // RL15
                end
            end
        end
    end

    // busy while a return is in flight
    assign busy = state_q != RTU_IDLE;
    // repeat never applies to any of these returns
    assign repeat_cancel = take_now && kind != RTU_K_NONE
                           && repeat_active; // RL5 RL8 RL11
    logic unused_ok;
    assign unused_ok = global_irq_mask_in ^ ent[RTU_STACK_DEPTH-1][0];
endmodule
`default_nettype wire

// ===== rtl/rtu_pkg.sv
// package: constants and types for the return instruction unit
`default_nettype none
package rtu_pkg;
    localparam int          RTU_PC_W       = 16;
    localparam int          RTU_STACK_DEPTH = 8;
    localparam int          RTU_OP_W       = 16;
    // opcode patterns
    localparam logic [5:0]  RTU_OP_CRET    = 6'h3B;   // 111011 tp cond_field cond_field
    localparam logic [15:0] RTU_OP_CRETD   = 16'hFE00; // upper byte marker
    localparam logic [7:0]  RTU_OP_CRETD_HI = 8'hFE;
    localparam logic [15:0] RTU_OP_RETURN_DELAYED    = 16'hFF00;
    localparam logic [15:0] RTU_OP_RETURN_ENABLE_IRQ    = 16'hBE3A;
    // field positions
    localparam int          RTU_TP_LSB     = 8;
    localparam int          RTU_CEN_LSB    = 4;
    localparam int          RTU_CVAL_LSB   = 0;
    // test selector codes
    localparam logic [1:0]  RTU_TP_PIN     = 2'h0;
    localparam logic [1:0]  RTU_TP_TC      = 2'h1;
    localparam logic [1:0]  RTU_TP_NTC     = 2'h2;
    localparam logic [1:0]  RTU_TP_NONE    = 2'h3;
    // cycle counts, wait periods p added per fetch
    localparam logic [2:0]  RTU_CYC_TAKEN  = 3'h4;
    localparam logic [2:0]  RTU_CYC_NOTAKE = 3'h2;
    localparam logic [2:0]  RTU_CYC_DELAY  = 3'h2;
    localparam logic [1:0]  RTU_DELAY_WORDS = 2'h2;
    localparam logic [1:0]  RTU_FETCH_TAKEN = 2'h3;
    localparam logic [1:0]  RTU_FETCH_ONE  = 2'h1;
    localparam logic [15:0] RTU_PC_RST     = 16'h0000;
    typedef enum logic [2:0] {
        RTU_K_NONE, RTU_K_CRET, RTU_K_CRETD, RTU_K_RETURN_DELAYED, RTU_K_RETURN_ENABLE_IRQ
    } rtu_kind_type;
    typedef struct packed {
        logic [31:0] accum;
        logic [31:0] accum_buffer;
        logic [15:0] aux_compare_reg;
        logic [15:0] index_reg;
        logic [15:0] processor_mode_reg;
        logic [31:0] product_reg;
        logic [15:0] status_reg_zero;
        logic [15:0] status_reg_one;
        logic [15:0] temp_reg_a;
        logic [15:0] temp_reg_b;
        logic [15:0] temp_reg_c;
    } rtu_shadow_type;
    // bit positions of unshadowed flags
    localparam int          RTU_ST0_MASK_BIT = 9;
    localparam int          RTU_ST1_XF_BIT   = 4;
endpackage
`default_nettype wire

// ===== rtl/rtu_stack_if.sv
// interface: stack pop request and top entry
`default_nettype none
interface rtu_stack_if;
    logic        pop;
    logic [15:0] top;
    modport ctrl (output pop, input top);
    modport stk  (input pop, output top);
endinterface
`default_nettype wire

// ===== rtl/rtu_stack.sv
// eight level lifo with bottom duplication on pop
`default_nettype none
module rtu_stack
    import rtu_pkg::*;
#(
    parameter int DEPTH = RTU_STACK_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        push,
    input  wire logic [15:0] push_data,
    rtu_stack_if.stk         sif,
    output logic [15:0]      entries [DEPTH]
);
    logic [15:0] ent_q [DEPTH];
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                ent_q[i] <= RTU_PC_RST;
            end
        end else if (sif.pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                ent_q[i] <= ent_q[i + 1]; // RL16
            end
        end else if (push) begin
            ent_q[0] <= push_data;
            for (int i = 1; i < DEPTH; i++) begin
                ent_q[i] <= ent_q[i - 1];
            end
        end
    end
    assign sif.top = ent_q[0];
    assign entries = ent_q;
endmodule
`default_nettype wire

// ===== tb/rtu_props.sv
// checker: assertions on the return unit ports
`default_nettype none
module rtu_props
    import rtu_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           sys_rst,
    input wire logic           busy,
    input wire logic           pc_load,
    input wire logic [15:0]    pc_value,
    input wire logic           flush_fetch,
    input wire logic           restore_valid,
    input wire rtu_shadow_type restore_out,
    input wire rtu_shadow_type shadow_in,
    input wire logic           global_irq_mask_clr,
    input wire logic           external_flag_in,
    input wire logic [2:0]     cycles_done,
    input wire logic [15:0]    stack_top_entry
);
    timeunit 1ns;
    timeprecision 1ps;
    rtu_shadow_type shadow_exp;
    always_comb begin
        shadow_exp = shadow_in;
        shadow_exp.status_reg_zero[RTU_ST0_MASK_BIT] = 1'b0;
        shadow_exp.status_reg_one[RTU_ST1_XF_BIT] = external_flag_in;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    load_once_a: assert property (pc_load |=> !pc_load)
        else $error("pc load wider than one cycle");
    load_busy_a: assert property (pc_load |-> $past(busy))
        else $error("pc load without a return in flight");
    pc_hold_a: assert property (!pc_load |-> $stable(pc_value))
        else $error("pc value moved without load");
    pop_top_a: assert property (flush_fetch |->
        pc_value == $past(stack_top_entry)) else $error("pc not old top");
    flush_cyc_a: assert property (flush_fetch |->
        pc_load && cycles_done == RTU_CYC_TAKEN) else $error("flush timing");
    short_cyc_a: assert property (pc_load && !flush_fetch |->
        cycles_done == RTU_CYC_DELAY) else $error("short count wrong");
    restore_go_a: assert property (restore_valid |->
        pc_load && global_irq_mask_clr) else $error("restore unpaired");
    mask_clr_a: assert property (global_irq_mask_clr |->
        restore_valid && cycles_done == 3'h4) else $error("mask clear");
    shadow_copy_a: assert property (restore_valid && $stable(shadow_in)
        && $stable(external_flag_in) |-> restore_out == shadow_exp)
        else $error("shadow not restored");
    cover property (restore_valid);
    cover property (flush_fetch);
    cover property (pc_load && !flush_fetch);
endmodule
bind rtu_core rtu_props rtu_props_i (.clk_sys, .sys_rst, .busy, .pc_load,
    .pc_value, .flush_fetch, .restore_valid, .restore_out, .shadow_in,
    .global_irq_mask_clr, .external_flag_in, .cycles_done, .stack_top_entry);
`default_nettype wire

// ===== tb/testbench.sv
// testbench: random return sequences against a bench model
`default_nettype none
module testbench
    import rtu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, sys_rst = 1, instr_valid = 0, word_wait = 0;
    logic repeat_active = 0, push = 0, carry_flag = 0, overflow_flag = 0;
    logic test_control_flag = 0, branch_input_pin = 1;
    logic global_irq_mask_in = 0, external_flag_in = 0;
    logic [15:0] instr_word = 0, push_data = 0, pc_next_seq = 0;
    logic [31:0] accum = 0;
    rtu_shadow_type shadow_in = '0, restore_out;
    logic busy, pc_load, flush_fetch, repeat_cancel, restore_valid;
    logic global_irq_mask_clr;
    logic [15:0] pc_value, stack_top_entry;
    logic [2:0] cycles_done;
    integer err_count = 0, comparisons = 0, seed = 32'hD294F215;
    logic [15:0] stk [8];
    rtu_core rtu_core_i (.clk_sys, .sys_rst, .instr_valid, .instr_word,
        .word_wait, .repeat_active, .push, .push_data, .pc_next_seq,
        .accum, .carry_flag, .overflow_flag, .test_control_flag,
        .branch_input_pin, .shadow_in, .global_irq_mask_in,
        .external_flag_in, .busy, .pc_load, .pc_value, .flush_fetch,
        .repeat_cancel, .restore_valid, .restore_out,
        .global_irq_mask_clr, .cycles_done, .stack_top_entry);
    always #2.5 clk_sys = ~clk_sys;
    task automatic check(input logic [63:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic bit cond_ok(logic [15:0] w);
        bit ok;
        ok = 1;
        if (w[7]) ok &= (accum == 0) == w[3];
        if (w[6]) ok &= accum[31] == w[2];
        if (w[5]) ok &= carry_flag == w[1];
        if (w[4]) ok &= overflow_flag == w[0];
        case (w[9:8])
            RTU_TP_PIN: ok &= !branch_input_pin;
            RTU_TP_TC: ok &= test_control_flag;
            RTU_TP_NTC: ok &= !test_control_flag;
            default: ;
        endcase
        return ok;
    endfunction
    // word held until the edge that takes it
    task automatic send(input logic [15:0] w, input bit st);
        instr_valid <= 1'b1;
        instr_word <= w;
        word_wait <= st;
        if (st) begin
            @(posedge clk_sys);
            word_wait <= 1'b0;
        end
        @(posedge clk_sys);
    endtask
    task automatic run_op(input int k);
        logic [15:0] w, v, exp_pc;
        logic [2:0] exp_cyc;
        rtu_shadow_type exp_sh;
        bit tk, dly;
        int n;
        w = k == 0 ? {RTU_OP_CRET, 10'($random(seed))}
          : k == 1 ? {RTU_OP_CRETD_HI, 8'($random(seed))}
          : k == 2 ? RTU_OP_RETURN_DELAYED : RTU_OP_RETURN_ENABLE_IRQ;
        repeat (1 + {$random(seed)} % 3) begin
            @(posedge clk_sys);
            v = 16'($random(seed));
            push <= 1'b1;
            push_data <= v;
            for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
            stk[0] = v;
        end
        @(posedge clk_sys);
        push <= 1'b0;
        accum <= $random(seed) & 32'h80000001;
        {carry_flag, overflow_flag, branch_input_pin} <= 3'($random(seed));
        test_control_flag <= 1'($random(seed));
        {repeat_active, global_irq_mask_in, external_flag_in}
            <= 3'($random(seed));
        shadow_in <= {7{$random(seed)}};
        pc_next_seq <= 16'($random(seed));
        repeat (3) @(posedge clk_sys);
        tk = k > 1 || cond_ok(w);
        dly = k == 1 || k == 2;
        exp_pc = tk ? stk[0] : pc_next_seq;
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        word_wait <= 1'b0;
        #1;
        check(repeat_cancel, repeat_active, "repeat cancel");
        @(posedge clk_sys);
        if (dly) begin
            {carry_flag, overflow_flag} <= ~{carry_flag, overflow_flag};
            accum <= ~accum;
            send({4'h7, 12'($random(seed))}, 1'($random(seed)));
            send({4'h7, 12'($random(seed))}, 1'($random(seed)));
        end
        instr_valid <= 1'b0;
        n = 0;
        #1;
        check(busy, !dly, "busy");
        while (pc_load !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        exp_cyc = dly ? RTU_CYC_DELAY : tk ? RTU_CYC_TAKEN : RTU_CYC_NOTAKE;
        check(pc_load, 1'b1, "no pc load");
        if (!dly) check(n + 1, exp_cyc, "latency");
        check(cycles_done, exp_cyc, "cyc");
        check(pc_value, exp_pc, "pc value");
        check(flush_fetch, tk && !dly, "flush");
        check(restore_valid, k == 3, "restore");
        check(global_irq_mask_clr, k == 3, "mask clear");
        exp_sh = shadow_in;
        exp_sh.status_reg_zero[RTU_ST0_MASK_BIT] = 1'b0;
        exp_sh.status_reg_one[RTU_ST1_XF_BIT] = external_flag_in;
        if (k == 3) check(restore_out === exp_sh, 1'b1, "shadow");
        if (tk) for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
        @(posedge clk_sys);
        #1;
        check(pc_load, 1'b0, "second load");
        check(busy, 1'b0, "idle after load");
        check(stack_top_entry, stk[0], "stack top");
    endtask
    initial begin
        #50us;
        err_count++;
        conclude;
    end
    initial begin
        for (int i = 0; i < 8; i++) stk[i] = 16'h0000;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        check(stack_top_entry, 16'h0000, "reset top");
        for (int k = 0; k < 4; k++) begin
            repeat (40) run_op(k);
            $display("test of kind %0d ended", k);
        end
        conclude;
    end
endmodule
`default_nettype wire
